/* core/timer16_counter.v */
/*
 * 16-bit up/down timer counter with compare and capture words, all reached
 * over an 8-bit register bus, all but compare reads through one shared high-byte holding register.
 * Assumes a single-cycle read or write strobe from the processor core, and
 * that prescaler taps and capture events come from logic on mclk_in.
 */
// What this block does
// RL1: Sixteen-bit words moved as two byte accesses
// RL2: One shared high-byte holding register
// RL3: Low-byte write loads holding plus new byte
// RL4: Low-byte read copies upper half into holding
// RL5: Compare reads bypass the holding register
// RL6: Software writes high first, reads low first
// RL7: Software masks interrupts around two-byte accesses
// RL8: One holding write may serve several words
// RL9: Zero clock select stops the counter
// RL10: Counter high location reaches holding register
// RL11: Each tick clears, increments or decrements
// RL12: Counter accessible with or without ticks
// RL13: Processor write beats counting that cycle
// RL14: Four-bit mode split over control A, B
// RL15: Overflow flag set where mode defines
// RL16: Core has clear, direction, max, zero
// RL17: Bottom is 0x0000, maximum 0xFFFF
// RL18: Top fixed, compare A or capture
// RL19: Single-cycle strobes, same-cycle read data
`include "timer16_regs.vh"

module timer16_counter (
  input wire mclk_in,
  input wire reset_n_in,
  input wire [7:0] bus_addr_in,
  input wire bus_write_in,
  input wire bus_read_in,
  input wire [7:0] bus_wdata_in,
  output reg [7:0] bus_rdata_out,
  input wire [3:0] prescale_tap_in,
  input wire ext_count_pin_in,
  input wire capture_event_in,
  output wire [15:0] timer_count_value_out,
  output wire [15:0] compare_value_a_out,
  output wire [15:0] compare_value_b_out,
  output wire [15:0] capture_value_out,
  output wire [3:0] waveform_mode_field_out,
  output wire timer_tick_out,
  output wire counting_down_out,
  output wire top_reached_out,
  output wire max_reached_out,
  output wire bottom_reached_out,
  output wire counter_overflow_flag_out
);
  localparam [3:0] MODE_NORMAL = 4'h0;
  localparam [3:0] MODE_PC8 = 4'h1;
  localparam [3:0] MODE_PC9 = 4'h2;
  localparam [3:0] MODE_PC10 = 4'h3;
  localparam [3:0] MODE_CTC_CMPA = 4'h4;
  localparam [3:0] MODE_FAST8 = 4'h5;
  localparam [3:0] MODE_FAST9 = 4'h6;
  localparam [3:0] MODE_FAST10 = 4'h7;
  localparam [3:0] MODE_PFC_CAP = 4'h8;
  localparam [3:0] MODE_PFC_CMPA = 4'h9;
  localparam [3:0] MODE_PC_CAP = 4'ha;
  localparam [3:0] MODE_PC_CMPA = 4'hb;
  localparam [3:0] MODE_CTC_CAP = 4'hc;
  localparam [3:0] MODE_FAST_CAP = 4'he;
  localparam [3:0] MODE_FAST_CMPA = 4'hf;

  // Mode classes, one-hot
  localparam [3:0] CLASS_NORMAL = 4'b0001;
  localparam [3:0] CLASS_CTC = 4'b0010;
  localparam [3:0] CLASS_FAST = 4'b0100;
  localparam [3:0] CLASS_DUAL = 4'b1000;

  reg [7:0] control_a;
  reg [7:0] control_b;
  reg [7:0] hold_byte;
  reg [15:0] count;
  reg [15:0] compare_a;
  reg [15:0] compare_b;
  reg [15:0] capture;
  reg count_down;
  reg overflow_flag;

  reg [3:0] mode_class;
  reg [15:0] top_value;
  reg top_from_capture;
  reg [15:0] next_count;
  reg next_count_down;
  reg core_clear;
  reg core_step;
  reg core_dir_down;
  reg overflow_event;

  wire [3:0] mode;
  wire tick;
  wire wr_count_lo;
  wire rd_count_lo;
  wire rd_capture_lo;
  wire wr_any_hi;
  wire at_top;
  wire at_max;
  wire at_bottom;

  assign mode = {control_b[`CTRL_B_WGM_HI_POS+1:`CTRL_B_WGM_HI_POS],
                 control_a[`CTRL_A_WGM_LO_POS+1:`CTRL_A_WGM_LO_POS]}; // RL14

  tick_source u_tick_source (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .clock_source_select_in(control_b[`CTRL_B_CS_POS+2:`CTRL_B_CS_POS]),
    .prescale_tap_in(prescale_tap_in),
    .ext_count_pin_in(ext_count_pin_in),
    .timer_tick_out(tick)
  );

  assign wr_count_lo = bus_write_in && (bus_addr_in == `COUNT_LO_ADDR);
  assign rd_count_lo = bus_read_in && (bus_addr_in == `COUNT_LO_ADDR);
  assign rd_capture_lo = bus_read_in && (bus_addr_in == `CAPTURE_LO_ADDR);
  assign wr_any_hi = bus_write_in && ((bus_addr_in == `COUNT_HI_ADDR) ||
                     (bus_addr_in == `CAPTURE_HI_ADDR) ||
                     (bus_addr_in == `COMPARE_A_HI_ADDR) ||
                     (bus_addr_in == `COMPARE_B_HI_ADDR));

  // Mode decode: class and top source
  always @* begin
    top_from_capture = 1'b0;
    case (mode)
      MODE_NORMAL: begin
        mode_class = CLASS_NORMAL;
        top_value = `COUNT_MAX;
      end
      MODE_PC8: begin
        mode_class = CLASS_DUAL;
        top_value = `TOP_8BIT; // RL18
      end
      MODE_PC9: begin
        mode_class = CLASS_DUAL;
        top_value = `TOP_9BIT; // RL18
      end
      MODE_PC10: begin
        mode_class = CLASS_DUAL;
        top_value = `TOP_10BIT; // RL18
      end
      MODE_CTC_CMPA: begin
        mode_class = CLASS_CTC;
        top_value = compare_a; // RL18
      end
      MODE_FAST8: begin
        mode_class = CLASS_FAST;
        top_value = `TOP_8BIT;
      end
      MODE_FAST9: begin
        mode_class = CLASS_FAST;
        top_value = `TOP_9BIT;
      end
      MODE_FAST10: begin
        mode_class = CLASS_FAST;
        top_value = `TOP_10BIT;
      end
      MODE_PFC_CAP, MODE_PC_CAP: begin
        mode_class = CLASS_DUAL;
        top_value = capture; // RL18
        top_from_capture = 1'b1;
      end
      MODE_PFC_CMPA, MODE_PC_CMPA: begin
        mode_class = CLASS_DUAL;
        top_value = compare_a;
      end
      MODE_CTC_CAP: begin
        mode_class = CLASS_CTC;
        top_value = capture;
        top_from_capture = 1'b1;
      end
      MODE_FAST_CAP: begin
        mode_class = CLASS_FAST;
        top_value = capture;
        top_from_capture = 1'b1;
      end
      MODE_FAST_CMPA: begin
        mode_class = CLASS_FAST;
        top_value = compare_a;
      end
      default: begin
        mode_class = CLASS_NORMAL;
        top_value = `COUNT_MAX;
      end
    endcase
  end

  assign at_top = (count == top_value);
  assign at_max = (count == `COUNT_MAX); // RL17
  assign at_bottom = (count == `COUNT_BOTTOM); // RL17

  // Sequence control: drives the core's clear, step and direction
  always @* begin
    core_clear = 1'b0;
    core_step = tick; // RL11
    core_dir_down = 1'b0;
    next_count_down = count_down;
    overflow_event = 1'b0;
    case (mode_class)
      CLASS_NORMAL: begin
        overflow_event = tick && at_max; // RL15
        next_count_down = 1'b0;
      end
      CLASS_CTC: begin
        core_clear = tick && (count >= top_value); // RL11
        overflow_event = tick && at_max; // RL15
        next_count_down = 1'b0;
      end
      CLASS_FAST: begin
        core_clear = tick && (count >= top_value);
        overflow_event = tick && (count >= top_value); // RL15
        next_count_down = 1'b0;
      end
      CLASS_DUAL: begin
        if (count_down) begin
          core_dir_down = !at_bottom;
          overflow_event = tick && at_bottom; // RL15
          if (tick && at_bottom) begin
            next_count_down = 1'b0;
          end
        end else begin
          core_dir_down = (count >= top_value);
          if (tick && (count >= top_value)) begin
            next_count_down = 1'b1;
          end
        end
      end
      default: begin
        next_count_down = 1'b0;
      end
    endcase
  end

  // Counter core: processor write first, then clear, then step
  always @* begin
    if (wr_count_lo) begin
      next_count = {hold_byte, bus_wdata_in}; // RL13 RL3 RL12
    end else if (core_clear) begin
      next_count = `COUNT_BOTTOM; // RL16
    end else if (core_step) begin
      if (core_dir_down) begin
        next_count = count - 16'h0001; // RL16
      end else begin
        next_count = count + 16'h0001;
      end
    end else begin
      next_count = count; // RL9
    end
  end

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= `WORD_RESET;
      count_down <= 1'b0;
    end else begin
      count <= next_count;
      count_down <= next_count_down;
    end
  end

  // Shared holding register: high writes, and low reads of count or capture
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_byte <= `HOLD_RESET;
    end else if (wr_any_hi) begin
      hold_byte <= bus_wdata_in; // RL2 RL10 RL8
    end else if (rd_count_lo) begin
      hold_byte <= count[15:8]; // RL4
    end else if (rd_capture_lo) begin
      hold_byte <= capture[15:8]; // RL4
    end
  end

  // Control, compare and capture words
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      control_a <= `CTRL_A_RESET;
      control_b <= `CTRL_B_RESET;
      compare_a <= `WORD_RESET;
      compare_b <= `WORD_RESET;
      capture <= `WORD_RESET;
    end else begin
      if (bus_write_in && (bus_addr_in == `CTRL_A_ADDR)) begin
        control_a <= bus_wdata_in;
      end
      if (bus_write_in && (bus_addr_in == `CTRL_B_ADDR)) begin
        control_b <= bus_wdata_in;
      end
      if (bus_write_in && (bus_addr_in == `COMPARE_A_LO_ADDR)) begin
        compare_a <= {hold_byte, bus_wdata_in}; // RL3 RL1
      end
      if (bus_write_in && (bus_addr_in == `COMPARE_B_LO_ADDR)) begin
        compare_b <= {hold_byte, bus_wdata_in}; // RL3
      end
      // Capture is writable only while it defines top
      if (bus_write_in && (bus_addr_in == `CAPTURE_LO_ADDR) && top_from_capture) begin
        capture <= {hold_byte, bus_wdata_in}; // RL3
      end else if (capture_event_in && !top_from_capture) begin
        capture <= count;
      end
    end
  end

  // Overflow flag: write one clears, a same-cycle set wins
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      overflow_flag <= 1'b0;
    end else if (overflow_event) begin
      overflow_flag <= 1'b1; // RL15
    end else if (bus_write_in && (bus_addr_in == `FLAG_ADDR) && bus_wdata_in[`FLAG_OVF_POS]) begin
      overflow_flag <= 1'b0;
    end
  end

  // Same-cycle read data; unmapped addresses read zero
  always @* begin
    bus_rdata_out = 8'h00;
    if (bus_read_in) begin
      case (bus_addr_in)
        `CTRL_A_ADDR: bus_rdata_out = control_a;
        `CTRL_B_ADDR: bus_rdata_out = control_b;
        `FLAG_ADDR: bus_rdata_out = {7'h00, overflow_flag};
        `COUNT_LO_ADDR: bus_rdata_out = count[7:0]; // RL19
        `COUNT_HI_ADDR: bus_rdata_out = hold_byte; // RL10
        `CAPTURE_LO_ADDR: bus_rdata_out = capture[7:0];
        `CAPTURE_HI_ADDR: bus_rdata_out = hold_byte;
        `COMPARE_A_LO_ADDR: bus_rdata_out = compare_a[7:0];
        `COMPARE_A_HI_ADDR: bus_rdata_out = compare_a[15:8]; // RL5
        `COMPARE_B_LO_ADDR: bus_rdata_out = compare_b[7:0];
        `COMPARE_B_HI_ADDR: bus_rdata_out = compare_b[15:8]; // RL5
        default: bus_rdata_out = 8'h00;
      endcase
    end
  end

  assign timer_count_value_out = count;
  assign compare_value_a_out = compare_a;
  assign compare_value_b_out = compare_b;
  assign capture_value_out = capture;
  assign waveform_mode_field_out = mode;
  assign timer_tick_out = tick;
  assign counting_down_out = count_down;
  assign top_reached_out = at_top;
  assign max_reached_out = at_max; // RL16
  assign bottom_reached_out = at_bottom; // RL16
  assign counter_overflow_flag_out = overflow_flag;
endmodule // timer16_counter

/* pkg/timer16_regs.vh */
/*
 * Register offsets, field positions, reset values and fixed top values of
 * the 16-bit timer counter with its shared high-byte holding register.
 * Assumes an 8-bit byte-addressed register bus in the processor's I/O space.
 */
`ifndef TIMER16_REGS_VH
`define TIMER16_REGS_VH

// Byte offsets on the register bus
`define CTRL_A_ADDR        8'h00
`define CTRL_B_ADDR        8'h01
`define FLAG_ADDR          8'h02
`define COUNT_LO_ADDR      8'h04
`define COUNT_HI_ADDR      8'h05
`define CAPTURE_LO_ADDR    8'h06
`define CAPTURE_HI_ADDR    8'h07
`define COMPARE_A_LO_ADDR  8'h08
`define COMPARE_A_HI_ADDR  8'h09
`define COMPARE_B_LO_ADDR  8'h0a
`define COMPARE_B_HI_ADDR  8'h0b

// Field positions
`define CTRL_A_WGM_LO_POS  0
`define CTRL_B_CS_POS      0
`define CTRL_B_WGM_HI_POS  3
`define FLAG_OVF_POS       0

// Reset values
`define CTRL_A_RESET       8'h00
`define CTRL_B_RESET       8'h00
`define HOLD_RESET         8'h00
`define WORD_RESET         16'h0000

// Extreme and fixed top values
`define COUNT_BOTTOM       16'h0000
`define COUNT_MAX          16'hffff
`define TOP_8BIT           16'h00ff
`define TOP_9BIT           16'h01ff
`define TOP_10BIT          16'h03ff

// Clock source select codes
`define CS_NONE            3'h0
`define CS_DIRECT          3'h1
`define CS_EXT_FALL        3'h6
`define CS_EXT_RISE        3'h7

`endif

/* core/tick_source.v */
/*
 * Timer tick selection: none, every cycle, one of four prescaler taps, or an
 * edge of the external count pin after a two-stage synchroniser.
 * Assumes the prescaler taps are one-cycle pulses in the mclk_in domain.
 */
`include "timer16_regs.vh"

module tick_source (
  input wire mclk_in,
  input wire reset_n_in,
  input wire [2:0] clock_source_select_in,
  input wire [3:0] prescale_tap_in,
  input wire ext_count_pin_in,
  output reg timer_tick_out
);
  reg pin_meta;
  reg pin_sync;
  reg pin_last;

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_last <= 1'b0;
    end else begin
      pin_meta <= ext_count_pin_in;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // Zero select leaves the counter without ticks
  always @* begin
    case (clock_source_select_in)
      `CS_NONE: timer_tick_out = 1'b0; // RL9
      `CS_DIRECT: timer_tick_out = 1'b1;
      3'h2: timer_tick_out = prescale_tap_in[0];
      3'h3: timer_tick_out = prescale_tap_in[1];
      3'h4: timer_tick_out = prescale_tap_in[2];
      3'h5: timer_tick_out = prescale_tap_in[3];
      `CS_EXT_FALL: timer_tick_out = pin_last & ~pin_sync;
      `CS_EXT_RISE: timer_tick_out = ~pin_last & pin_sync;
      default: timer_tick_out = 1'b0;
    endcase
  end
endmodule // tick_source

/* sim/timer16_counter_sva.sv */
/* Port-level checks for the 16-bit timer counter and its holding byte.
   Assumes the bench bind below and single-cycle bus strobes on mclk_in. */
`include "timer16_regs.vh"

module timer16_counter_sva (
  input wire mclk_in,
  input wire reset_n_in,
  input wire [7:0] bus_addr_in,
  input wire bus_write_in,
  input wire bus_read_in,
  input wire [7:0] bus_wdata_in,
  input wire [7:0] bus_rdata_out,
  input wire [15:0] timer_count_value_out,
  input wire [15:0] compare_value_a_out,
  input wire [15:0] capture_value_out,
  input wire [3:0] waveform_mode_field_out,
  input wire timer_tick_out,
  input wire max_reached_out,
  input wire bottom_reached_out,
  input wire counter_overflow_flag_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  logic [7:0] hold;
  logic [7:0] next_hold;
  wire wr_lo = bus_write_in && bus_addr_in == `COUNT_LO_ADDR;
  wire hi_addr = bus_addr_in[0] && bus_addr_in >= `COUNT_HI_ADDR && bus_addr_in <= `COMPARE_B_HI_ADDR;
  // Reference copy of the shared holding byte
  always_comb begin
    next_hold = hold;
    if (bus_write_in && hi_addr) next_hold = bus_wdata_in;
    if (bus_read_in && bus_addr_in == `COUNT_LO_ADDR) next_hold = timer_count_value_out[15:8];
    if (bus_read_in && bus_addr_in == `CAPTURE_LO_ADDR) next_hold = capture_value_out[15:8];
  end
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) hold <= `HOLD_RESET;
    else hold <= next_hold;
  end
  a_word_write_load: assert property (wr_lo |=> timer_count_value_out == {$past(hold), $past(bus_wdata_in)})
    else $error("count not loaded from holding byte and low byte");
  a_high_read_hold: assert property (bus_read_in && bus_addr_in == `COUNT_HI_ADDR |-> bus_rdata_out == hold)
    else $error("count high read not served from holding byte");
  a_compare_direct_read: assert property (bus_read_in && bus_addr_in == `COMPARE_A_HI_ADDR
    |-> bus_rdata_out == compare_value_a_out[15:8])
    else $error("compare high read not direct");
  a_stop_holds_count: assert property (!timer_tick_out && !wr_lo |=> $stable(timer_count_value_out))
    else $error("count moved without tick");
  a_tick_steps_up: assert property (timer_tick_out && !wr_lo && waveform_mode_field_out == 4'h0
    |=> timer_count_value_out == $past(timer_count_value_out) + 16'h0001)
    else $error("normal mode tick did not add one");
  a_overflow_sets: assert property (timer_tick_out && !wr_lo && waveform_mode_field_out == 4'h0
    && timer_count_value_out == `COUNT_MAX |=> counter_overflow_flag_out)
    else $error("overflow flag not set at wrap");
  a_extreme_flags: assert property (bottom_reached_out == (timer_count_value_out == `COUNT_BOTTOM)
    && max_reached_out == (timer_count_value_out == `COUNT_MAX))
    else $error("bottom or max indication wrong");
  a_mode_low_bits: assert property (bus_write_in && bus_addr_in == `CTRL_A_ADDR
    |=> waveform_mode_field_out[1:0] == $past(bus_wdata_in[1:0]))
    else $error("mode low bits not taken from control a");
  a_idle_rdata: assert property (!bus_read_in |-> bus_rdata_out == 8'h00)
    else $error("read data driven without read strobe");
  a_low_read_direct: assert property (bus_read_in && bus_addr_in == `COUNT_LO_ADDR
    |-> bus_rdata_out == timer_count_value_out[7:0])
    else $error("count low read not served in the same cycle");
  a_capture_high_hold: assert property (bus_read_in && bus_addr_in == `CAPTURE_HI_ADDR
    |-> bus_rdata_out == hold)
    else $error("capture high read not served from holding byte");
endmodule // timer16_counter_sva

bind timer16_counter timer16_counter_sva timer16_counter_sva_i (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
  .bus_addr_in(bus_addr_in), .bus_write_in(bus_write_in), .bus_read_in(bus_read_in),
  .bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out), .timer_count_value_out(timer_count_value_out),
  .compare_value_a_out(compare_value_a_out), .capture_value_out(capture_value_out),
  .waveform_mode_field_out(waveform_mode_field_out), .timer_tick_out(timer_tick_out),
  .max_reached_out(max_reached_out), .bottom_reached_out(bottom_reached_out),
  .counter_overflow_flag_out(counter_overflow_flag_out));

/* sim/cpu_model.sv */
/* Processor side of the byte register bus: one strobe per access.
   Assumes the caller orders byte accesses of a word itself. */
module cpu_model (
  input wire mclk_in,
  input wire [7:0] bus_rdata_in,
  output logic [7:0] bus_addr_out = 8'h00,
  output logic bus_write_out = 1'b0,
  output logic bus_read_out = 1'b0,
  output logic [7:0] bus_wdata_out = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // Single master, accesses never nested, so no access disturbs the holding byte mid-word
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk_in);
    bus_addr_out = a;
    bus_wdata_out = v;
    bus_write_out = 1'b1;
    @(negedge mclk_in);
    bus_write_out = 1'b0;
    bus_addr_out = ~a;
    bus_wdata_out = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge mclk_in);
    bus_addr_out = a;
    bus_read_out = 1'b1;
    @(posedge mclk_in);
    v = bus_rdata_in;
    @(negedge mclk_in);
    bus_read_out = 1'b0;
    bus_addr_out = ~a;
  endtask
endmodule // cpu_model

/* sim/timer16_counter_tb.sv */
/* Self-checking bench for the 16-bit timer counter byte access.
   Assumes the design and checker files are compiled before it. */
`include "timer16_regs.vh"

module timer16_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  wire [7:0] bus_addr, bus_wdata, bus_rdata;
  wire bus_write, bus_read;
  wire [15:0] count_value, cmp_a, cmp_b;
  wire [3:0] mode;
  wire bot, ovf;
  int num_errors = 0;
  int checks = 0;
  logic [7:0] d;
  logic cap_evt = 1'b0;
  logic ext_pin = 1'b0;
  always #4 mclk_in = ~mclk_in;
  timer16_counter timer16_counter_i (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .bus_addr_in(bus_addr),
    .bus_write_in(bus_write), .bus_read_in(bus_read), .bus_wdata_in(bus_wdata), .bus_rdata_out(bus_rdata),
    .prescale_tap_in(4'h0), .ext_count_pin_in(ext_pin), .capture_event_in(cap_evt),
    .timer_count_value_out(count_value), .compare_value_a_out(cmp_a), .compare_value_b_out(cmp_b),
    .capture_value_out(), .waveform_mode_field_out(mode), .timer_tick_out(), .counting_down_out(),
    .top_reached_out(), .max_reached_out(), .bottom_reached_out(bot), .counter_overflow_flag_out(ovf));
  cpu_model cpu_model_i (.mclk_in(mclk_in), .bus_rdata_in(bus_rdata), .bus_addr_out(bus_addr),
    .bus_write_out(bus_write), .bus_read_out(bus_read), .bus_wdata_out(bus_wdata));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_ovf(input int lim);
    int n;
    n = 0;
    while (ovf !== 1'b1 && n < lim) begin
      @(negedge mclk_in);
      n++;
    end
    if (ovf !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      close_out();
    end
  endtask
  initial begin
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in) reset_n_in = 1'b1;
    cpu_model_i.rd(`CTRL_B_ADDR, d);
    chk8(d, `CTRL_B_RESET);
    chk8({7'h0, bot}, 8'h01);
    cpu_model_i.rd(8'h30, d);
    chk8(d, 8'h00);
    $display("test reset done");
    cpu_model_i.wr(`COUNT_HI_ADDR, 8'h01);
    cpu_model_i.wr(`COUNT_LO_ADDR, 8'hff);
    chk16(count_value, 16'h01ff);
    cpu_model_i.rd(`COUNT_LO_ADDR, d);
    chk8(d, 8'hff);
    cpu_model_i.rd(`COUNT_HI_ADDR, d);
    chk8(d, 8'h01);
    $display("test word access done");
    cpu_model_i.wr(`COMPARE_A_HI_ADDR, 8'h12);
    cpu_model_i.wr(`COMPARE_A_LO_ADDR, 8'h34);
    cpu_model_i.wr(`COMPARE_B_LO_ADDR, 8'h56);
    chk16(cmp_a, 16'h1234);
    chk16(cmp_b, 16'h1256);
    cpu_model_i.rd(`COUNT_LO_ADDR, d);
    cpu_model_i.rd(`COMPARE_B_HI_ADDR, d);
    chk8(d, 8'h12);
    cpu_model_i.rd(`COUNT_HI_ADDR, d);
    chk8(d, 8'h01);
    repeat (5) @(negedge mclk_in);
    chk16(count_value, 16'h01ff);
    $display("test shared holding done");
    cpu_model_i.wr(`COUNT_HI_ADDR, 8'hff);
    cpu_model_i.wr(`COUNT_LO_ADDR, 8'hfd);
    cpu_model_i.wr(`CTRL_B_ADDR, {5'h00, `CS_DIRECT});
    wait_ovf(10);
    cpu_model_i.wr(`CTRL_B_ADDR, {5'h00, `CS_NONE});
    cpu_model_i.rd(`FLAG_ADDR, d);
    chk8(d, 8'h01);
    cpu_model_i.wr(`FLAG_ADDR, 8'h01);
    cpu_model_i.rd(`FLAG_ADDR, d);
    chk8(d, 8'h00);
    $display("test overflow done");
    cpu_model_i.wr(`CTRL_B_ADDR, {5'h00, `CS_DIRECT});
    cpu_model_i.wr(`COUNT_HI_ADDR, 8'h40);
    cpu_model_i.wr(`COUNT_LO_ADDR, 8'h00);
    chk16(count_value, 16'h4000);
    cpu_model_i.rd(`COUNT_LO_ADDR, d);
    chk8(d, 8'h01);
    cpu_model_i.rd(`COUNT_HI_ADDR, d);
    chk8(d, 8'h40);
    cpu_model_i.wr(`CTRL_B_ADDR, {5'h00, `CS_NONE});
    $display("test running access done");
    cpu_model_i.wr(`CTRL_A_ADDR, 8'h03);
    cpu_model_i.wr(`CTRL_B_ADDR, 8'h18);
    chk8({4'h0, mode}, 8'h0f);
    cpu_model_i.wr(`CTRL_A_ADDR, 8'h00);
    cpu_model_i.wr(`CTRL_B_ADDR, 8'h00);
    $display("test mode field done");
    cpu_model_i.wr(`COUNT_HI_ADDR, 8'h5a);
    cpu_model_i.wr(`COUNT_LO_ADDR, 8'h3c);
    @(negedge mclk_in) cap_evt = 1'b1;
    @(negedge mclk_in) cap_evt = 1'b0;
    cpu_model_i.rd(`CAPTURE_LO_ADDR, d);
    chk8(d, 8'h3c);
    cpu_model_i.rd(`CAPTURE_HI_ADDR, d);
    chk8(d, 8'h5a);
    $display("test capture read done");
    cpu_model_i.wr(`COUNT_HI_ADDR, 8'h00);
    cpu_model_i.wr(`COUNT_LO_ADDR, 8'h00);
    cpu_model_i.wr(`CTRL_B_ADDR, {5'h00, `CS_EXT_RISE});
    @(negedge mclk_in) ext_pin = 1'b1;
    repeat (6) @(negedge mclk_in);
    ext_pin = 1'b0;
    repeat (6) @(negedge mclk_in);
    cpu_model_i.wr(`CTRL_B_ADDR, {5'h00, `CS_NONE});
    chk16(count_value, 16'h0001);
    $display("test external tick done");
    // Clear-on-top mode, top 0001: two ticks from zero end at zero
    cpu_model_i.wr(`COMPARE_A_HI_ADDR, 8'h00);
    cpu_model_i.wr(`COMPARE_A_LO_ADDR, 8'h01);
    cpu_model_i.wr(`COUNT_LO_ADDR, 8'h00);
    cpu_model_i.wr(`CTRL_B_ADDR, 8'h09);
    cpu_model_i.wr(`CTRL_B_ADDR, 8'h08);
    chk16(count_value, 16'h0000);
    // Dual-slope mode, top 00ff: up to top, then one step down
    cpu_model_i.wr(`CTRL_B_ADDR, 8'h00);
    cpu_model_i.wr(`CTRL_A_ADDR, 8'h01);
    cpu_model_i.wr(`COUNT_LO_ADDR, 8'hfe);
    cpu_model_i.wr(`CTRL_B_ADDR, 8'h01);
    cpu_model_i.wr(`CTRL_B_ADDR, 8'h00);
    chk16(count_value, 16'h00fe);
    cpu_model_i.wr(`CTRL_A_ADDR, 8'h00);
    $display("test mode sequences done");
    close_out();
  end
endmodule // timer16_counter_tb
